// File: hdl/tcoc_axil.sv
// axi4-lite slave front end, one write and one read in flight
// assumes the register file answers decode in the same cycle
`timescale 1ns/1ps
`default_nettype none
module tcoc_axil
	import tcoc_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output tcoc_req_t              wr_req,
	output logic                   wr_en,
	input  wire logic              wr_ok,
	output logic [ADDR_W-1:0]      rd_addr,
	output logic                   rd_en,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_ok
);
	logic aw_have_q;
	logic w_have_q;
	logic ar_have_q;
	wire  logic aw_take = s_axi_awvalid && s_axi_awready;
	wire  logic w_take  = s_axi_wvalid && s_axi_wready;
	wire  logic ar_take = s_axi_arvalid && s_axi_arready;

	// ****************************************************************
	// handshakes
	// ****************************************************************
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;
	assign s_axi_arready = !ar_have_q && !s_axi_rvalid;
	assign wr_en         = aw_have_q && w_have_q && !s_axi_bvalid;
	assign rd_en         = ar_have_q && !s_axi_rvalid;

	// ****************************************************************
	// write path
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			wr_req       <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else begin
			if (aw_take) begin
				aw_have_q   <= 1'b1;
				wr_req.addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_have_q    <= 1'b1;
				wr_req.data <= s_axi_wdata;
				wr_req.strb <= s_axi_wstrb;
			end
			if (wr_en) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// read path
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ar_have_q    <= 1'b0;
			rd_addr      <= '0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else begin
			if (ar_take) begin
				ar_have_q <= 1'b1;
				rd_addr   <= s_axi_araddr;
			end
			if (rd_en) begin
				ar_have_q    <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_ok ? rd_data : '0;
				s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// File: hdl/tcoc_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes inputs are asynchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module tcoc_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// ****************************************************************
	// two stages
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule
`default_nettype wire

// File: hdl/tcoc_top.sv
// 16-bit reload timer with square-wave clock output and control register
// assumes aclk is the oscillator; pins arrive asynchronously
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] clock-output mode drives an equal high/low square wave on the pin
// [R2] clock-output mode advances the low count byte at half aclk
// [R3] count runs to overflow and then loads the reload bytes
// [R4] overflows in clock-output mode raise no interrupt request
// [R5] output rate is input clock over four times (65536 - reload)
// [R6] generated clock leaves on the shared clock pin
// [R7] software enables output, clears select, loads reload, count, then runs
// [R8] baud source and clock output share the same reload value
// [R9] overflow sets flag bit 7 unless a serial select is set
// [R10] enabled trigger falling edge sets flag bit 6; software clears
// [R11] a set trigger flag requests the timer interrupt, even set by software
// [R12] bit 5 picks receive clock: timer 1 or this overflow
// [R13] bit 4 picks transmit clock: timer 1 or this overflow
// [R14] control resets to zero; single bits can be set or cleared
// [R15] mode bit 1 turns the shared pin into the clock output
// [R16] run bit holds the count when clear, counts when set
// [R17] select bit picks divided clock or falling edges of the pin
module tcoc_top
	import tcoc_pkg::*;
#(
	parameter int unsigned PRE_DIV_TIMER = DIV_TIMER,
	parameter int unsigned PRE_DIV_FAST  = DIV_FAST
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              clock_out_pin_i,
	output logic                   clock_out_pin_o,
	output logic                   clock_out_pin_oe,
	input  wire logic              ext_trigger_pin,
	input  wire logic              timer1_overflow,
	output logic                   serial_rx_tick,
	output logic                   serial_tx_tick,
	output logic                   timer_irq_req,
	output logic                   irq
);
	// ****************************************************************
	// parameter checks
	// ****************************************************************
	if (PRE_DIV_TIMER < 1 || PRE_DIV_TIMER > (1 << PRE_W)) begin : g_chk_t
		$error("timer prescale out of range");
	end
	if (PRE_DIV_FAST < 1 || PRE_DIV_FAST > (1 << PRE_W)) begin : g_chk_f
		$error("fast prescale out of range");
	end

	localparam logic [PRE_W-1:0] PRE_T_TOP = PRE_W'(PRE_DIV_TIMER - 1);
	localparam logic [PRE_W-1:0] PRE_F_TOP = PRE_W'(PRE_DIV_FAST - 1);

	// ****************************************************************
	// bus front end and decode
	// ****************************************************************
	tcoc_req_t         wr_req;
	logic              wr_en;
	logic              wr_ok;
	logic [ADDR_W-1:0] rd_addr;
	logic              rd_en;
	logic [31:0]       rd_data;
	logic              rd_ok;

	tcoc_axil u_bus (
		.aclk          (aclk),
		.aresetn       (aresetn),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_req        (wr_req),
		.wr_en         (wr_en),
		.wr_ok         (wr_ok),
		.rd_addr       (rd_addr),
		.rd_en         (rd_en),
		.rd_data       (rd_data),
		.rd_ok         (rd_ok)
	);

	wire logic [IDX_W-1:0] wr_idx = wr_req.addr[ADDR_W-1:2];
	wire logic [IDX_W-1:0] rd_idx = rd_addr[ADDR_W-1:2];
	wire logic [7:0]       wbyte  = wr_req.data[7:0];
	wire logic             wlane  = wr_en && wr_req.strb[0];
	wire logic wr_ctrl = wlane && (wr_idx == IDX_CTRL);
	wire logic wr_mode = wlane && (wr_idx == IDX_MODE);
	wire logic wr_rl   = wlane && (wr_idx == IDX_RLD_L);
	wire logic wr_rh   = wlane && (wr_idx == IDX_RLD_H);
	wire logic wr_cl   = wlane && (wr_idx == IDX_CNT_L);
	wire logic wr_ch   = wlane && (wr_idx == IDX_CNT_H);
	wire logic wr_iclr = wlane && (wr_idx == IDX_ICLR);
	wire logic wr_ien  = wlane && (wr_idx == IDX_IEN);
	wire logic wr_bset = wlane && (wr_idx == IDX_BSET);
	wire logic wr_bclr = wlane && (wr_idx == IDX_BCLR);
	wire logic wr_cnt  = wr_cl || wr_ch;
	wire logic rd_is_stat = (rd_idx == IDX_STAT);
	wire logic rd_is_wo   = (rd_idx == IDX_ICLR) || (rd_idx == IDX_BSET)
		|| (rd_idx == IDX_BCLR);
	wire logic rd_map     = (rd_idx >= IDX_CTRL && rd_idx <= IDX_CNT_H)
		|| (rd_idx >= IDX_STAT && rd_idx <= IDX_BCLR);

	assign wr_ok = (wr_idx >= IDX_CTRL && wr_idx <= IDX_CNT_H)
		|| (wr_idx >= IDX_ICLR && wr_idx <= IDX_BCLR);

	// ****************************************************************
	// state
	// ****************************************************************
	tcoc_ctrl_t        ctrl_q;
	tcoc_ctrl_t        ctrl_d;
	tcoc_mode_t        mode_q;
	logic [15:0]       cnt_q;
	logic [15:0]       cnt_d;
	logic [15:0]       rld_q;
	logic [15:0]       rld_d;
	logic [PRE_W-1:0]  pre_q;
	logic [STAT_W-1:0] stat_q;
	logic [STAT_W-1:0] ien_q;
	logic              clk_q;
	logic              pin_prev_q;
	logic              trg_prev_q;
	logic [1:0]        pins_s;

	tcoc_sync #(.W(2)) u_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.d       ({ext_trigger_pin, clock_out_pin_i}),
		.q       (pins_s)
	);

	// ****************************************************************
	// tick and event decode
	// ****************************************************************
	wire logic run      = ctrl_q.run_control;
	wire logic baud     = ctrl_q.serial_rx_clock_select
		|| ctrl_q.serial_tx_clock_select;
	wire logic clk_mode = mode_q.clock_out_enable;
	wire logic fast     = clk_mode || baud;
	wire logic ext_mode = ctrl_q.counter_timer_select && !clk_mode; // [R17]
	wire logic pin_fall = pin_prev_q && !pins_s[0];
	wire logic trg_fall = trg_prev_q && !pins_s[1];
	wire logic [PRE_W-1:0] pre_top = fast ? PRE_F_TOP : PRE_T_TOP; // [R2]
	wire logic pre_wrap = (pre_q >= pre_top);
	wire logic tick     = run && (ext_mode ? pin_fall : pre_wrap); // [R16]
	wire logic ovf      = tick && (cnt_q == CNT_TOP);
	wire logic reload_ovf = baud || clk_mode
		|| !ctrl_q.capture_reload_select; // [R8]
	wire logic ext_ev   = trg_fall && ctrl_q.ext_trigger_enable;
	wire logic ovf_flag_set = ovf && !baud; // [R9]
	wire logic ovf_irq_ev   = ovf_flag_set && !clk_mode; // [R4]
	wire logic fast_run = run && fast && !ext_mode;
	wire logic [STAT_W-1:0] stat_ev = {ext_ev, ovf_irq_ev};
	wire logic [STAT_W-1:0] stat_clr = wr_iclr ? wbyte[STAT_W-1:0] : '0;

	// ****************************************************************
	// next-state logic
	// ****************************************************************
	always_comb begin
		cnt_d = cnt_q;
		if (ovf) begin
			cnt_d = reload_ovf ? rld_q : CNT_RST; // [R3]
		end else if (tick) begin
			cnt_d = cnt_q + 16'h0001;
		end
		if (ext_ev && !baud && !ctrl_q.capture_reload_select) begin
			cnt_d = rld_q; // [R10]
		end
		if (wr_cl) begin
			cnt_d[7:0] = wbyte;
		end
		if (wr_ch) begin
			cnt_d[15:8] = wbyte;
		end
	end

	always_comb begin
		rld_d = rld_q;
		if (ext_ev && !baud && ctrl_q.capture_reload_select) begin
			rld_d = cnt_q;
		end
		if (wr_rl) begin
			rld_d[7:0] = wbyte;
		end
		if (wr_rh) begin
			rld_d[15:8] = wbyte;
		end
	end

	always_comb begin
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = tcoc_ctrl_t'(wbyte);
		end
		if (wr_bset) begin
			ctrl_d = ctrl_d | tcoc_ctrl_t'(wbyte); // [R14]
		end
		if (wr_bclr) begin
			ctrl_d = ctrl_d & ~tcoc_ctrl_t'(wbyte); // [R14]
		end
		if (ovf_flag_set) begin
			ctrl_d.overflow_flag = 1'b1; // [R9]
		end
		if (ext_ev) begin
			ctrl_d.ext_trigger_flag = 1'b1; // [R10]
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= tcoc_ctrl_t'(CTRL_RST); // [R14]
			mode_q <= tcoc_mode_t'(MODE_RST);
			cnt_q  <= CNT_RST;
			rld_q  <= CNT_RST;
		end else begin
			ctrl_q <= ctrl_d;
			cnt_q  <= cnt_d;
			rld_q  <= rld_d;
			if (wr_mode) begin
				mode_q <= {6'h00, wbyte[1:0]};
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_q      <= '0;
			clk_q      <= 1'b0;
			pin_prev_q <= 1'b0;
			trg_prev_q <= 1'b0;
		end else begin
			pre_q      <= (!run || pre_wrap) ? '0 : pre_q + 1'b1;
			pin_prev_q <= pins_s[0];
			trg_prev_q <= pins_s[1];
			if (ovf && clk_mode) begin
				clk_q <= !clk_q; // [R1] [R5]
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stat_q         <= '0;
			ien_q          <= '0;
			serial_rx_tick <= 1'b0;
			serial_tx_tick <= 1'b0;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | stat_ev;
			if (wr_ien) begin
				ien_q <= wbyte[STAT_W-1:0];
			end
			serial_rx_tick <= ctrl_q.serial_rx_clock_select ? ovf
				: timer1_overflow; // [R12]
			serial_tx_tick <= ctrl_q.serial_tx_clock_select ? ovf
				: timer1_overflow; // [R13]
		end
	end

	// ****************************************************************
	// outputs and read mux
	// ****************************************************************
	assign clock_out_pin_o  = clk_q; // [R6]
	assign clock_out_pin_oe = clk_mode; // [R15]
	assign timer_irq_req = ctrl_q.ext_trigger_flag
		|| (ctrl_q.overflow_flag && !clk_mode); // [R11] [R4]
	assign irq   = |(stat_q & ien_q);
	assign rd_ok = rd_map;
	assign rd_data =
		(rd_idx == IDX_CTRL)  ? {PAD_24, ctrl_q} :
		(rd_idx == IDX_MODE)  ? {PAD_24, mode_q} :
		(rd_idx == IDX_RLD_L) ? {PAD_24, rld_q[7:0]} :
		(rd_idx == IDX_RLD_H) ? {PAD_24, rld_q[15:8]} :
		(rd_idx == IDX_CNT_L) ? {PAD_24, cnt_q[7:0]} :
		(rd_idx == IDX_CNT_H) ? {PAD_24, cnt_q[15:8]} :
		(rd_idx == IDX_IEN)   ? {30'h00000000, ien_q} :
		(rd_is_stat)          ? {30'h00000000, stat_q} :
		(rd_is_wo)            ? 32'h00000000 : 32'h00000000;

	// ****************************************************************
	// assertions
	// ****************************************************************
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_ovf_out;
		ovf && clk_mode;
	endsequence
	sequence s_ovf_reload;
		ovf && reload_ovf && !wr_cnt && !ext_ev;
	endsequence

	clk_toggle_a: assert property (s_ovf_out |=> clock_out_pin_o != $past(clk_q)) // [R1]
		else $error("clock output did not toggle on overflow");
	half_rate_a: assert property (fast_run && $past(fast_run) |-> tick != $past(tick)) // [R2]
		else $error("fast tick is not every other cycle");
	reload_a: assert property (s_ovf_reload |=> cnt_q == $past(rld_q)) // [R3]
		else $error("count not reloaded on overflow");
	no_irq_a: assert property (clk_mode && !ctrl_q.ext_trigger_flag |-> !timer_irq_req) // [R4]
		else $error("clock-out overflow raised interrupt request");
	pin_oe_a: assert property (clock_out_pin_oe == mode_q.clock_out_enable) // [R15]
		else $error("pin direction does not follow mode");
	baud_flag_a: assert property (ovf && baud && !ctrl_q.overflow_flag && !wr_ctrl && !wr_bset |=> !ctrl_q.overflow_flag) // [R9]
		else $error("overflow flag set in serial clock mode");
	ovf_flag_a: assert property (ovf && !baud |=> ctrl_q.overflow_flag) // [R9]
		else $error("overflow flag not set");
	ext_flag_a: assert property (ext_ev |=> ctrl_q.ext_trigger_flag && stat_q[STAT_EXT]) // [R10]
		else $error("trigger flag not set");
	irq_req_a: assert property (ctrl_q.ext_trigger_flag |-> timer_irq_req) // [R11]
		else $error("trigger flag without request");
	rx_sel_a: assert property (ctrl_q.serial_rx_clock_select && ovf |=> serial_rx_tick) // [R12]
		else $error("receive tick missing");
	tx_sel_a: assert property (!ctrl_q.serial_tx_clock_select |=> serial_tx_tick == $past(timer1_overflow)) // [R13]
		else $error("transmit tick not from timer 1");
	ctrl_rst_a: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=> ctrl_q == CTRL_RST) // [R14]
		else $error("control not cleared by reset");
	hold_a: assert property (!run && !wr_cnt && !ext_ev |=> cnt_q == $past(cnt_q)) // [R16]
		else $error("count moved while stopped");
	ext_clk_a: assert property (ext_mode && tick |-> pin_fall) // [R17]
		else $error("external count without pin edge");
endmodule
`default_nettype wire

// File: inc/tcoc_pkg.sv
// constants, field layouts and carriers for the timer clock-out block
// assumes a 32-bit axi4-lite bus, one 8-bit register per aligned word
`default_nettype none
package tcoc_pkg;
	// ****************************************************************
	// register map (word index, byte address is four times it)
	// ****************************************************************
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned IDX_W  = 10;
	localparam logic [IDX_W-1:0] IDX_CTRL  = 10'h0c8;
	localparam logic [IDX_W-1:0] IDX_MODE  = 10'h0c9;
	localparam logic [IDX_W-1:0] IDX_RLD_L = 10'h0ca;
	localparam logic [IDX_W-1:0] IDX_RLD_H = 10'h0cb;
	localparam logic [IDX_W-1:0] IDX_CNT_L = 10'h0cc;
	localparam logic [IDX_W-1:0] IDX_CNT_H = 10'h0cd;
	localparam logic [IDX_W-1:0] IDX_STAT  = 10'h0d0;
	localparam logic [IDX_W-1:0] IDX_ICLR  = 10'h0d1;
	localparam logic [IDX_W-1:0] IDX_IEN   = 10'h0d2;
	localparam logic [IDX_W-1:0] IDX_BSET  = 10'h0d3;
	localparam logic [IDX_W-1:0] IDX_BCLR  = 10'h0d4;

	// ****************************************************************
	// fields and reset values
	// ****************************************************************
	typedef struct packed {
		logic overflow_flag;
		logic ext_trigger_flag;
		logic serial_rx_clock_select;
		logic serial_tx_clock_select;
		logic ext_trigger_enable;
		logic run_control;
		logic counter_timer_select;
		logic capture_reload_select;
	} tcoc_ctrl_t;

	typedef struct packed {
		logic [5:0] reserved;
		logic       clock_out_enable;
		logic       down_count_enable;
	} tcoc_mode_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0]       data;
		logic [3:0]        strb;
	} tcoc_req_t;

	localparam int unsigned STAT_W   = 2;
	localparam int unsigned STAT_OVF = 0;
	localparam int unsigned STAT_EXT = 1;
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [7:0]  MODE_RST = 8'h00;
	localparam logic [15:0] CNT_RST  = 16'h0000;
	localparam logic [15:0] CNT_TOP  = 16'hffff;
	localparam logic [23:0] PAD_24   = 24'h000000;

	// ****************************************************************
	// prescaler and bus answers
	// ****************************************************************
	localparam int unsigned DIV_TIMER = 6;
	localparam int unsigned DIV_FAST  = 2;
	localparam int unsigned PRE_W     = 3;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// File: verif/tcoc_pin_model.sv
// pin partner: drives the shared pin when the block lets go, times the wave
// assumes a single clock; pin levels are looked at on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tcoc_pin_model (
	input  wire logic aclk,
	input  wire logic pin_o,
	input  wire logic pin_oe,
	output logic      pin_i,
	output var int    hi_len,
	output var int    lo_len
);
	logic drv = 1'b1;
	logic lvl = 1'b0;
	int   run = 0;
	assign pin_i = pin_oe ? pin_o : drv;
	always @(negedge aclk) begin
		run++;
		if (!pin_oe)
			run = 0;
		else if (pin_o !== lvl) begin
			if (lvl)
				hi_len = run;
			else
				lo_len = run;
			run = 0;
			lvl = pin_o;
		end
	end
	task automatic edges(input int n);
		repeat (n) begin
			repeat (4) @(posedge aclk);
			drv <= 1'b0;
			repeat (4) @(posedge aclk);
			drv <= 1'b1;
		end
	endtask
endmodule
`default_nettype wire

// File: verif/tcoc_top_bench.sv
// self-checking bench for the timer clock-out block
// assumes the package and the pin partner model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tcoc_top_bench
	import tcoc_pkg::*;
();
	localparam int FAST = 2;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic [31:0] rdata;
	logic [1:0]  bresp, rresp;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0, ext_pin = 1'b1;
	logic        t1_ovf = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic        pin_o, pin_oe, pin_i, rx_tick, tx_tick, tirq, irq;
	logic [15:0] r;
	int          hi_len, lo_len, half, seed, rxc, txc, m_ctrl;
	int          rxb, txb;
	int          bad_count = 0;
	int          n_checks = 0;
	always #2.5 aclk = ~aclk;
	tcoc_top #(.PRE_DIV_FAST(FAST)) i_tcoc_top (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .clock_out_pin_i(pin_i),
		.clock_out_pin_o(pin_o), .clock_out_pin_oe(pin_oe),
		.ext_trigger_pin(ext_pin), .timer1_overflow(t1_ovf),
		.serial_rx_tick(rx_tick), .serial_tx_tick(tx_tick),
		.timer_irq_req(tirq), .irq(irq));
	tcoc_pin_model i_pin (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe),
		.pin_i(pin_i), .hi_len(hi_len), .lo_len(lo_len));
	always @(negedge aclk) begin
		rxc += int'(rx_tick);
		txc += int'(tx_tick);
	end
	function automatic logic [11:0] ad(input logic [9:0] i);
		return {i, 2'b00};
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			if (tb) chk("bresp", 32'(er), 32'(bresp));
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
	endtask
	task automatic rd(input string nm, input logic [11:0] a, input logic [7:0] m,
		input logic [7:0] e, input logic [1:0] er);
		logic ta, tr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = arvalid & arready;
			tr = rvalid;
			if (tr) chk(nm, {24'h000000, e}, rdata & {24'hffffff, m});
			if (tr) chk("rresp", 32'(er), 32'(rresp));
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end while (!tr);
		rready <= 1'b0;
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		wrap_up();
	end
	initial begin
		seed = 13;
		r = 16'hffe0 | 16'($random(seed) & 15);
		half = FAST * (65536 - int'(r));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rd("ctrl", ad(IDX_CTRL), 8'hff, CTRL_RST, RESP_OKAY);
		rd("mode", ad(IDX_MODE), 8'hff, MODE_RST, RESP_OKAY);
		rd("unmapped", 12'hffc, 8'hff, 8'h00, RESP_SLVERR);
		wr(ad(IDX_STAT), 8'h01, RESP_SLVERR);
		m_ctrl = 8'h0d;
		wr(ad(IDX_BSET), 8'(m_ctrl), RESP_OKAY);
		m_ctrl &= ~8'h09;
		wr(ad(IDX_BCLR), 8'h09, RESP_OKAY);
		rd("ctrl", ad(IDX_CTRL), 8'hff, 8'(m_ctrl), RESP_OKAY);
		wr(ad(IDX_CTRL), 8'h00, RESP_OKAY);
		$display("test registers done");
		wr(ad(IDX_MODE), 8'h02, RESP_OKAY);
		wr(ad(IDX_BCLR), 8'h02, RESP_OKAY);
		wr(ad(IDX_RLD_L), r[7:0], RESP_OKAY);
		wr(ad(IDX_RLD_H), r[15:8], RESP_OKAY);
		wr(ad(IDX_CNT_L), r[7:0], RESP_OKAY);
		wr(ad(IDX_CNT_H), r[15:8], RESP_OKAY);
		wr(ad(IDX_IEN), 8'h03, RESP_OKAY);
		wr(ad(IDX_BSET), 8'h04, RESP_OKAY);
		repeat (6 * half) @(posedge aclk);
		chk("high time", half, hi_len);
		chk("low time", half, lo_len);
		chk("pin_oe", 1, pin_oe);
		chk("timer_irq_req", 0, tirq);
		chk("irq", 0, irq);
		rd("status", ad(IDX_STAT), 8'h01, 8'h00, RESP_OKAY);
		$display("test clock out done");
		for (int b = 4; b < 6; b++) begin
			wr(ad(IDX_BSET), 8'(1 << b), RESP_OKAY);
			wr(ad(IDX_BCLR), 8'h80, RESP_OKAY);
			rxb = rxc;
			txb = txc;
			repeat (4 * half) @(posedge aclk);
			chk("rx ticks", (b == 5) ? 4 : 0, rxc - rxb);
			chk("tx ticks", (b == 4) ? 4 : 0, txc - txb);
			rd("ovf flag", ad(IDX_CTRL), 8'h80, 8'h00, RESP_OKAY);
			wr(ad(IDX_BCLR), 8'(1 << b), RESP_OKAY);
		end
		repeat (half + 8) @(posedge aclk);
		rd("ovf flag", ad(IDX_CTRL), 8'h80, 8'h80, RESP_OKAY);
		rxb = rxc;
		txb = txc;
		t1_ovf <= 1'b1;
		@(posedge aclk);
		t1_ovf <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("rx timer1", 1, rxc - rxb);
		chk("tx timer1", 1, txc - txb);
		$display("test serial done");
		wr(ad(IDX_CTRL), 8'h08, RESP_OKAY);
		wr(ad(IDX_ICLR), 8'h03, RESP_OKAY);
		ext_pin <= 1'b0;
		repeat (8) @(posedge aclk);
		chk("timer_irq_req", 1, tirq);
		chk("irq", 1, irq);
		rd("ext flag", ad(IDX_CTRL), 8'h40, 8'h40, RESP_OKAY);
		rd("status", ad(IDX_STAT), 8'h02, 8'h02, RESP_OKAY);
		wr(ad(IDX_IEN), 8'h01, RESP_OKAY);
		chk("irq masked", 0, irq);
		wr(ad(IDX_BCLR), 8'h40, RESP_OKAY);
		chk("timer_irq_req", 0, tirq);
		wr(ad(IDX_BSET), 8'h40, RESP_OKAY);
		chk("timer_irq_req", 1, tirq);
		wr(ad(IDX_CTRL), 8'h02, RESP_OKAY);
		ext_pin <= 1'b1;
		$display("test trigger done");
		wr(ad(IDX_MODE), 8'h00, RESP_OKAY);
		wr(ad(IDX_CNT_L), 8'h00, RESP_OKAY);
		wr(ad(IDX_CNT_H), 8'h00, RESP_OKAY);
		i_pin.edges(3);
		repeat (8) @(posedge aclk);
		rd("count held", ad(IDX_CNT_L), 8'hff, 8'h00, RESP_OKAY);
		wr(ad(IDX_BSET), 8'h04, RESP_OKAY);
		i_pin.edges(5);
		repeat (8) @(posedge aclk);
		rd("count edges", ad(IDX_CNT_L), 8'hff, 8'h05, RESP_OKAY);
		$display("test counter done");
		wrap_up();
	end
endmodule
`default_nettype wire
